/* File: logic/vbs_pkg.sv */
// vbi slicer package: register map, fields, rates and bit counts
package vbs_pkg;

    // apb register byte offsets
    localparam logic [7:0] ADDR_CTRL      = 8'h00;  // enables, output mode, system, framing
    localparam logic [7:0] ADDR_LINE_CODE = 8'h04;  // sixteen 2-bit line codes
    localparam logic [7:0] ADDR_CAPTION   = 8'h08;  // caption bytes, read-only
    localparam logic [7:0] ADDR_STATUS    = 8'h0c;  // ready flag and detect bits

    // control register field positions
    localparam int CTRL_ODD_EN   = 0;
    localparam int CTRL_EVEN_EN  = 1;
    localparam int CTRL_RAW_SEL  = 2;
    localparam int CTRL_INS_SEL  = 3;
    localparam int CTRL_MIXED    = 4;
    localparam int CTRL_TT_LSB   = 5;   // two-bit teletext system field
    localparam int CTRL_FRAM_LSB = 8;   // eight-bit framing byte

    // reset values
    localparam logic [31:0] CTRL_RESET = 32'h0000_e400;  // framing byte 0xe4, all off
    localparam logic [31:0] LINE_RESET = 32'h0000_0000;

    // line codes
    localparam logic [1:0] CODE_NONE     = 2'h0;
    localparam logic [1:0] CODE_CAPTION  = 2'h1;
    localparam logic [1:0] CODE_TELETEXT = 2'h2;
    localparam logic [1:0] CODE_WSS_CGMS = 2'h3;

    // clock rate and data rates in hz
    localparam longint CLK_HZ      = 200000000;
    localparam longint RATE_TT_60  = 5727272;
    localparam longint RATE_TT_B50 = 6937500;
    localparam longint RATE_TT_A50 = 6203125;
    localparam longint RATE_TT_C50 = 5734375;
    localparam longint RATE_TT_D50 = 5645787;
    localparam longint RATE_CC     = 503500;
    localparam longint RATE_WSS    = 5000000;
    localparam longint RATE_CGMS   = 447443;

    // phase accumulator: step = rate * 2^24 / clock
    localparam int ACC_W = 24;
    function automatic logic [ACC_W-1:0] rate_step(input longint hz);
        longint s;
        s = (hz <<< ACC_W) / CLK_HZ;
        return s[ACC_W-1:0];
    endfunction : rate_step

    // bits per line
    localparam logic [8:0] BITS_TT_C60 = 9'd272;
    localparam logic [8:0] BITS_TT_B50 = 9'd344;
    localparam logic [8:0] BITS_TT_A50 = 9'd304;
    localparam logic [8:0] BITS_TT_B60 = 9'd280;
    localparam logic [8:0] BITS_TT_C50 = 9'd272;
    localparam logic [8:0] BITS_TT_D   = 9'd280;
    localparam logic [8:0] BITS_CC     = 9'd16;
    localparam logic [8:0] BITS_WSS    = 9'd84;
    localparam logic [8:0] BITS_CGMS   = 9'd20;

    // raw sample clamp limits
    localparam logic [7:0] RAW_MIN = 8'h01;
    localparam logic [7:0] RAW_MAX = 8'hfe;

    // video output source
    typedef enum logic [1:0] {VBS_OUT_VIDEO, VBS_OUT_RAW, VBS_OUT_SLICED} vbs_out_t;

    // slicer line state
    typedef enum logic [1:0] {VBS_IDLE, VBS_HUNT, VBS_DATA, VBS_DONE} vbs_state_t;

endpackage : vbs_pkg

/* File: logic/vbs_slicer.sv */
// vbi slicer control: mode decode, bit slicer, output routing and apb registers
//
// Functional notes
// - four extraction paths: raw, burst, registers, pins
// - data-rate clock, threshold compare, burst on luma
// - sliced bytes readable through two registers
// - serial data pin plus bit-valid pin
// - format 1, fm 0, system 0: 272 bits
// - both detects 0, system 0: 344 bits
// - format 0, fm 1, system 0: 304 bits
// - system 1: 60 hz system b, 280 bits
// - system 2: 50 hz system c, 272 bits
// - system 3: system d, rate by field rate
// - code 1: caption, 16 bits always
// - code 3: wss on 50 hz, cgms on 60
// - separate odd and even field enables
// - serial pins run whenever processing enabled
// - code 0 lines carry no vbi output
// - register mode keeps last two bytes
// - insert mode puts sliced data in stream
// - raw mode puts adc samples in stream
// - mixed mode: code 3 lines output raw
// - sixteen 2-bit codes, ends cover two lines
// - programmable framing byte finds first teletext bit
// - raw samples clamped to 1..254
// - pollable flag for complete caption capture
`timescale 1ns/1ps
module vbs_slicer
    import vbs_pkg::*;
#(
    parameter int LINE_W = 4
) (
    // clock, reset, enable
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic        clk_en,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // video timing and detection from the decoder
    input  wire logic        line_start,
    input  wire logic [LINE_W-1:0] vbi_line_index,
    input  wire logic        in_vbi_range,
    input  wire logic        odd_field,
    input  wire logic        format_60hz_detect,
    input  wire logic        fm_colour_detect_bit,
    input  wire logic        active_window,
    // luma adc and slice threshold
    input  wire logic [7:0]  luma_sample,
    input  wire logic [7:0]  slice_threshold,
    input  wire logic [7:0]  video_in,
    // video output stream
    output logic [7:0]       video_out,
    output logic             vbi_active,
    // serial pins
    output logic             slice_serial_pin,
    output logic             slice_valid_pin
);
    import vbs_pkg::*;

    // configuration registers
    logic [31:0] ctrl;              // enables, mode, system, framing byte
    logic [31:0] line_codes;        // vbi_line_code_n fields
    logic [7:0]  caption_byte_one;  // older captured byte
    logic [7:0]  caption_byte_two;  // newest captured byte
    logic        caption_data_ready_flag;

    // decoded control fields
    logic       odd_field_vbi_enable;
    logic       even_field_vbi_enable;
    logic       raw_sample_select;
    logic       sliced_insert_select;
    logic       mixed_raw_sliced_enable;
    logic [1:0] teletext_system_select;
    logic [7:0] teletext_framing_byte;
    assign odd_field_vbi_enable    = ctrl[CTRL_ODD_EN];
    assign even_field_vbi_enable   = ctrl[CTRL_EVEN_EN];
    assign raw_sample_select       = ctrl[CTRL_RAW_SEL];
    assign sliced_insert_select    = ctrl[CTRL_INS_SEL];
    assign mixed_raw_sliced_enable = ctrl[CTRL_MIXED];
    assign teletext_system_select  = ctrl[CTRL_TT_LSB +: 2];
    assign teletext_framing_byte   = ctrl[CTRL_FRAM_LSB +: 8];

    // detect inputs pass two flops: they come from another domain
    logic [1:0] fmt_sync;
    logic [1:0] fm_sync;
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            fmt_sync <= 2'h0;
            fm_sync  <= 2'h0;
        end else if (clk_en) begin
            fmt_sync <= {fmt_sync[0], format_60hz_detect};
            fm_sync  <= {fm_sync[0], fm_colour_detect_bit};
        end
    end
    logic is_60hz;
    logic is_fm;
    assign is_60hz = fmt_sync[1];
    assign is_fm   = fm_sync[1];

    // line code for the current line; outside the vbi range code 0 applies
    logic [1:0] vbi_line_code;
    assign vbi_line_code = in_vbi_range ? line_codes[2*vbi_line_index +: 2]
                                        : CODE_NONE;

    // field gate
    logic field_enabled;
    assign field_enabled = odd_field ? odd_field_vbi_enable
                                     : even_field_vbi_enable;

    // per-line mode decode: data rate step and bit count
    logic [ACC_W-1:0] next_step;
    logic [8:0]       next_bits;
    logic             next_teletext;
    always_comb begin
        next_step     = '0;
        next_bits     = '0;
        next_teletext = 1'b0;
        if (vbi_line_code == CODE_CAPTION) begin
            next_step = rate_step(RATE_CC);
            next_bits = BITS_CC;
        end else if (vbi_line_code == CODE_WSS_CGMS) begin
            if (is_60hz) begin
                next_step = rate_step(RATE_CGMS);
                next_bits = BITS_CGMS;
            end else begin
                next_step = rate_step(RATE_WSS);
                next_bits = BITS_WSS;
            end
        end else if (vbi_line_code == CODE_TELETEXT) begin
            next_teletext = 1'b1;
            case (teletext_system_select)
                2'h1: begin
                    next_step = rate_step(RATE_TT_60);
                    next_bits = BITS_TT_B60;
                end
                2'h2: begin
                    next_step = rate_step(RATE_TT_C50);
                    next_bits = BITS_TT_C50;
                end
                2'h3: begin
                    next_step = is_60hz ? rate_step(RATE_TT_60)
                                        : rate_step(RATE_TT_D50);
                    next_bits = BITS_TT_D;
                end
                default: begin
                    if (is_60hz) begin
                        next_step = rate_step(RATE_TT_60);
                        next_bits = BITS_TT_C60;
                    end else if (is_fm) begin
                        next_step = rate_step(RATE_TT_A50);
                        next_bits = BITS_TT_A50;
                    end else begin
                        next_step = rate_step(RATE_TT_B50);
                        next_bits = BITS_TT_B50;
                    end
                end
            endcase
        end
    end

    // latched line setup
    vbs_state_t       state;
    logic [ACC_W-1:0] step;
    logic [8:0]       bits_left;
    logic             line_teletext;
    logic [1:0]       line_code;
    logic [ACC_W-1:0] phase;
    logic [7:0]       hunt_shift;   // framing byte search window
    logic [7:0]       byte_shift;   // assembles bytes for the registers
    logic [2:0]       byte_bits;
    logic             bit_tick;
    logic             slice_bit;

    // data-rate clock: phase wrap marks one bit time
    assign bit_tick  = (phase + step) < phase;
    assign slice_bit = luma_sample > slice_threshold;

    // slicer line sequencer
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state         <= VBS_IDLE;
            step          <= '0;
            bits_left     <= '0;
            line_teletext <= 1'b0;
            line_code     <= CODE_NONE;
            phase         <= '0;
            hunt_shift    <= 8'h00;
        end else if (clk_en) begin
            if (line_start) begin
                // code 0 or a disabled field leaves the slicer idle
                line_code     <= field_enabled ? vbi_line_code : CODE_NONE;
                step          <= next_step;
                bits_left     <= next_bits;
                line_teletext <= next_teletext;
                phase         <= '0;
                hunt_shift    <= 8'h00;
                if (field_enabled && vbi_line_code != CODE_NONE) begin
                    state <= next_teletext ? VBS_HUNT : VBS_DATA;
                end else begin
                    state <= VBS_IDLE;
                end
            end else begin
                phase <= phase + step;
                case (state)
                    VBS_HUNT: begin
                        // slide until the framing byte is seen
                        if (bit_tick) begin
                            hunt_shift <= {hunt_shift[6:0], slice_bit};
                            if ({hunt_shift[6:0], slice_bit} == teletext_framing_byte) begin
                                state <= VBS_DATA;
                            end
                        end
                    end
                    VBS_DATA: begin
                        if (bit_tick) begin
                            bits_left <= bits_left - 9'd1;
                            if (bits_left == 9'd1) begin
                                state <= VBS_DONE;
                            end
                        end
                    end
                    default: begin
                        state <= state;
                    end
                endcase
            end
        end
    end

    // a data bit is valid when the rate clock ticks in the data phase
    logic data_bit;
    assign data_bit = (state == VBS_DATA) && bit_tick && !line_start;

    // serial pins run whenever a line is being sliced, regardless of mode
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            slice_serial_pin <= 1'b0;
            slice_valid_pin  <= 1'b0;
        end else if (clk_en) begin
            slice_valid_pin  <= data_bit;
            if (data_bit) begin
                slice_serial_pin <= slice_bit;
            end
        end
    end

    // byte assembly and caption capture; only the newest pair is kept
    logic register_mode;
    logic caption_read;
    logic byte_done;
    assign register_mode = !raw_sample_select && !sliced_insert_select;
    assign byte_done     = data_bit && byte_bits == 3'h7;
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            byte_shift       <= 8'h00;
            byte_bits        <= 3'h0;
            caption_byte_one <= 8'h00;
            caption_byte_two <= 8'h00;
        end else if (clk_en) begin
            if (line_start) begin
                byte_bits <= 3'h0;
            end else if (data_bit) begin
                // caption data is sent lsb first
                byte_shift <= {slice_bit, byte_shift[7:1]};
                byte_bits  <= byte_bits + 3'h1;
                if (byte_done && register_mode) begin
                    caption_byte_one <= caption_byte_two;
                    caption_byte_two <= {slice_bit, byte_shift[7:1]};
                end
            end
        end
    end

    // ready flag: set on a completed caption pair, cleared by reading it
    logic pair_done;
    assign pair_done = byte_done && register_mode && line_code == CODE_CAPTION
                       && bits_left == 9'd1;
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            caption_data_ready_flag <= 1'b0;
        end else if (clk_en) begin
            // a new pair arriving with the read wins over the clear
            if (pair_done) begin
                caption_data_ready_flag <= 1'b1;
            end else if (caption_read) begin
                caption_data_ready_flag <= 1'b0;
            end
        end
    end

    // output routing: sliced insert, raw samples, or normal video
    vbs_out_t   out_sel;
    logic [7:0] raw_clamped;
    logic       line_on;
    assign line_on = state != VBS_IDLE && line_code != CODE_NONE
                     && active_window;
    assign raw_clamped = (luma_sample < RAW_MIN) ? RAW_MIN :
                         (luma_sample > RAW_MAX) ? RAW_MAX : luma_sample;
    always_comb begin
        out_sel = VBS_OUT_VIDEO;
        // raw and insert both set is invalid; raw wins
        if (line_on && raw_sample_select) begin
            out_sel = VBS_OUT_RAW;
        end else if (line_on && sliced_insert_select) begin
            if (mixed_raw_sliced_enable && line_code == CODE_WSS_CGMS) begin
                out_sel = VBS_OUT_RAW;
            end else begin
                out_sel = VBS_OUT_SLICED;
            end
        end
    end

    // registered video output; sliced bits burst as the raw clamp limits 0xfe and 0x01
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            video_out  <= 8'h00;
            vbi_active <= 1'b0;
        end else if (clk_en) begin
            vbi_active <= out_sel != VBS_OUT_VIDEO;
            case (out_sel)
                VBS_OUT_RAW:    video_out <= raw_clamped;
                VBS_OUT_SLICED: video_out <= slice_bit ? RAW_MAX : RAW_MIN;
                default:        video_out <= video_in;
            endcase
        end
    end

    // apb slave: one wait state, unmapped offsets answer with an error
    logic apb_access;
    assign apb_access   = psel && penable && !pready;
    assign caption_read = apb_access && !pwrite && paddr == ADDR_CAPTION;
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl       <= CTRL_RESET;
            line_codes <= LINE_RESET;
            prdata     <= 32'h0000_0000;
            pready     <= 1'b0;
            pslverr    <= 1'b0;
        end else if (clk_en) begin
            pready  <= apb_access;
            pslverr <= 1'b0;
            if (apb_access) begin
                prdata <= 32'h0000_0000;
                if (paddr == ADDR_CTRL) begin
                    if (pwrite) ctrl <= {16'h0000, pwdata[15:0]};
                    else        prdata <= ctrl;
                end else if (paddr == ADDR_LINE_CODE) begin
                    if (pwrite) line_codes <= pwdata;
                    else        prdata <= line_codes;
                end else if (paddr == ADDR_CAPTION) begin
                    prdata <= {16'h0000, caption_byte_two,
                               caption_byte_one};
                end else if (paddr == ADDR_STATUS) begin
                    prdata <= {29'h0, is_fm, is_60hz, caption_data_ready_flag};
                end else begin
                    pslverr <= 1'b1;
                end
            end
        end
    end

endmodule : vbs_slicer

/* File: sim/vbs_slicer_monitor.sv */
// port checker bound to the vbi slicer
`timescale 1ns/1ps
module vbs_slicer_monitor #(
    parameter int LINE_W = 4
) (
    // clock and reset
    input wire logic       ref_clk,
    input wire logic       sys_rst,
    // apb side
    input wire logic       psel,
    input wire logic       penable,
    input wire logic [7:0] paddr,
    input wire logic       pready,
    input wire logic       pslverr,
    // line timing and outputs
    input wire logic       line_start,
    input wire logic       in_vbi_range,
    input wire logic       vbi_active,
    input wire logic [7:0] video_out,
    input wire logic       slice_serial_pin,
    input wire logic       slice_valid_pin
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // access phase awaiting its answer
    sequence s_wait;
        psel && penable && !pready;
    endsequence
    // line whose code is forced to none
    sequence s_off_line;
        line_start && !in_vbi_range;
    endsequence
    a_apb_one_wait: assert property (s_wait |=> pready)
        else $error("apb answer late");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready too long");
    a_err_unmapped: assert property (pready && paddr > 8'h0c |-> pslverr)
        else $error("unmapped, no error");
    a_err_mapped: assert property (pready && paddr <= 8'h0c && paddr[1:0] == 2'b00
        |-> !pslverr) else $error("mapped, error");
    a_valid_pulse: assert property (slice_valid_pin |=> !slice_valid_pin [*8])
        else $error("valid too close");
    a_serial_update: assert property ($changed(slice_serial_pin) |-> slice_valid_pin)
        else $error("serial moved alone");
    a_raw_range: assert property (vbi_active |-> video_out != 8'h00 && video_out != 8'hff)
        else $error("output out of range");
    a_idle_line: assert property (s_off_line |-> ##2 !slice_valid_pin [*8])
        else $error("code 0 line sliced");
    a_idle_video: assert property (s_off_line |-> ##2 !vbi_active [*4])
        else $error("code 0 line output");
endmodule : vbs_slicer_monitor

bind vbs_slicer vbs_slicer_monitor #(.LINE_W(LINE_W)) i_mon (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .paddr(paddr),
    .pready(pready), .pslverr(pslverr), .line_start(line_start), .in_vbi_range(in_vbi_range),
    .vbi_active(vbi_active), .video_out(video_out), .slice_serial_pin(slice_serial_pin),
    .slice_valid_pin(slice_valid_pin));

/* File: sim/vbs_video_source.sv */
// front end model: one luma level per sliced pattern bit
`timescale 1ns/1ps
module vbs_video_source (
    // clock and reset
    input wire logic        ref_clk,
    input wire logic        sys_rst,
    // pattern control
    input wire logic        load,
    input wire logic [15:0] word,
    input wire logic [7:0]  hi,
    input wire logic [7:0]  lo,
    // slicer feedback and luma out
    input wire logic        slice_valid_pin,
    output logic [7:0]      luma_sample
);
    logic [3:0] bit_idx;  // current pattern bit
    // step after each sliced bit so the next sample meets fresh data
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            bit_idx <= 4'h0;
        end else if (load) begin
            bit_idx <= 4'h0;  // lsb goes out first
        end else if (slice_valid_pin) begin
            bit_idx <= bit_idx + 4'h1;
        end
    end
    // level above or below the slice threshold
    assign luma_sample = word[bit_idx] ? hi : lo;
endmodule : vbs_video_source

/* File: sim/vbs_slicer_tb_top.sv */
// self-checking bench for the vbi slicer
`timescale 1ns/1ps
module vbs_slicer_tb_top;
    import vbs_pkg::*;
    // design and source signals
    logic        ref_clk, sys_rst, clk_en, psel, penable, pwrite, pready, pslverr, e, va;
    logic        line_start, in_vbi_range, odd_field, format_60hz_detect, fm_colour_detect_bit;
    logic        vbi_active, slice_serial_pin, slice_valid_pin, src_load;
    logic [3:0]  vbi_line_index;
    logic [7:0]  paddr, luma_sample, video_in, video_out, src_hi, src_lo, vo, v;
    logic [15:0] src_word;
    logic [31:0] pwdata, prdata, q;
    int          mismatches, num_checks, cycles, cnt, per;
    real         d;
    // modes: detects, line code, system, bits per line, rate
    int     f60_t  [10] = '{1, 0, 0, 0, 0, 0, 1, 0, 1, 0};
    int     fm_t   [10] = '{0, 0, 1, 1, 1, 1, 1, 0, 0, 0};
    int     code_t [10] = '{2, 2, 2, 2, 2, 2, 2, 3, 3, 1};
    int     sys_t  [10] = '{0, 0, 0, 1, 2, 3, 3, 0, 0, 0};
    int     bits_t [10] = '{272, 344, 304, 280, 272, 280, 280, 84, 20, 16};
    longint rate_t [10] = '{RATE_TT_60, RATE_TT_B50, RATE_TT_A50, RATE_TT_60, RATE_TT_C50,
                            RATE_TT_D50, RATE_TT_60, RATE_WSS, RATE_CGMS, RATE_CC};

    vbs_slicer #(.LINE_W(4)) i_dut (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .line_start(line_start), .vbi_line_index(vbi_line_index),
        .in_vbi_range(in_vbi_range), .odd_field(odd_field),
        .format_60hz_detect(format_60hz_detect), .fm_colour_detect_bit(fm_colour_detect_bit),
        .active_window(1'b1), .luma_sample(luma_sample), .slice_threshold(8'h80),
        .video_in(video_in), .video_out(video_out), .vbi_active(vbi_active),
        .slice_serial_pin(slice_serial_pin), .slice_valid_pin(slice_valid_pin));

    vbs_video_source i_src (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .load(src_load), .word(src_word), .hi(src_hi),
        .lo(src_lo), .slice_valid_pin(slice_valid_pin), .luma_sample(luma_sample));

    // 200 mhz clock
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    // raw samples never reach 0 or 255
    function automatic logic [7:0] clamp(input logic [7:0] x);
        return (x == 8'h00) ? 8'h01 : (x == 8'hff) ? 8'hfe : x;
    endfunction : clamp

    task automatic chk(input logic ok, input string msg);
        num_checks++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("wrong value at %0t ns: %s", $time, msg);
        end
    endtask : chk

    task automatic finish_test;
        $display("checks %0d, mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test

    // hang guard: the run takes about 112k cycles
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 120000) begin
            mismatches++;
            finish_test();
        end
    end

    // one apb transfer; waits for pready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        chk(n == 2, "apb latency");
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb

    // program a mode, run a line, count bits and the first period
    task automatic run_line(input logic [7:0] cb, input int i, input logic fld, rng);
        int idle, n_all;
        logic [3:0] ix;
        ix = 4'($urandom_range(15, 0));  // any code field
        apb(1'b1, ADDR_CTRL, {16'h0, 8'hff, cb});  // framing byte of all ones
        apb(1'b1, ADDR_LINE_CODE, 32'(code_t[i]) << (2 * ix));
        format_60hz_detect <= 1'(f60_t[i]); fm_colour_detect_bit <= 1'(fm_t[i]);
        odd_field <= fld; in_vbi_range <= rng; vbi_line_index <= ix;
        src_load <= 1'b1; video_in <= 8'($urandom);
        repeat (4) @(posedge ref_clk);  // let detects cross synchronisers
        src_load <= 1'b0; line_start <= 1'b1;
        @(posedge ref_clk);
        line_start <= 1'b0;
        cnt = 0; idle = 0; n_all = 0; per = 0;
        while (idle < int'((cnt == 0 ? 20.0 : 3.0) * real'(CLK_HZ) / real'(rate_t[i])) + 20) begin
            @(posedge ref_clk);
            #1;
            idle++; n_all++;
            if (n_all == 30 || (slice_valid_pin === 1'b1 && cnt == 1)) begin
                vo = video_out; va = vbi_active;
            end
            if (slice_valid_pin === 1'b1) begin
                if (cnt == 1) per = idle;
                chk(slice_serial_pin === src_word[cnt % 16], "serial bit");
                cnt++; idle = 0;
            end
        end
    endtask : run_line

    // ready flag, caption pair, clear on read
    task automatic cap_check;
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(q[0] === 1'b1, "ready flag set");
        apb(1'b0, ADDR_CAPTION, 32'h0);
        chk(q[15:0] === src_word, "caption pair");
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(q[0] === 1'b0, "flag cleared");
    endtask : cap_check

    initial begin
        {psel, penable, pwrite, line_start, in_vbi_range, odd_field, src_load} = '0;
        {format_60hz_detect, fm_colour_detect_bit, paddr, pwdata, vbi_line_index} = '0;
        clk_en = 1'b1; video_in = 8'h00; src_word = 16'hffff; src_hi = 8'hf0; src_lo = 8'h10;
        mismatches = 0; num_checks = 0; cycles = 0; sys_rst = 1'b1;
        void'($urandom(32'h91c4));
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b0;
        // reset values, fields, read-only, unmapped
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk(q === CTRL_RESET && e === 1'b0, "ctrl reset");
        apb(1'b0, ADDR_LINE_CODE, 32'h0);
        chk(q === LINE_RESET, "line code reset");
        apb(1'b1, ADDR_CTRL, 32'hffff_a573);  // raw and insert never both set
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk(q === 32'h0000_a573, "ctrl fields");
        apb(1'b1, ADDR_CAPTION, 32'hffff_ffff);
        apb(1'b0, ADDR_CAPTION, 32'h0);
        chk(q === 32'h0, "caption read-only");
        apb(1'b0, 8'h10, 32'h0);
        chk(e === 1'b1, "unmapped offset");
        // every mode, both fields; caption last, register mode
        f60_t[9] = $urandom_range(1, 0); fm_t[9] = $urandom_range(1, 0);
        for (int i = 0; i < 10; i++) begin
            src_word <= (code_t[i] == 1) ? 16'($urandom) : 16'hffff;
            run_line((code_t[i] == 1) ? 8'h03 : 8'(8'h0b | (sys_t[i] << 5)), i, 1'(i % 2), 1'b1);
            chk(cnt == bits_t[i], "bits");
            d = real'(per) - real'(CLK_HZ) / real'(rate_t[i]);
            chk(d*d < 2.25, "rate");
            if (code_t[i] != 1) chk(vo === 8'hfe || vo === 8'h01, "sliced burst");
        end
        cap_check();
        src_word <= 16'($urandom);
        run_line(8'h02, 9, 1'b0, 1'b1);  // even field only, newer pair
        cap_check();
        // disabled field and code 0 pass video
        run_line(8'h01, 7, 1'b0, 1'b1);
        chk(cnt == 0 && vo === video_in, "even field off");
        run_line(8'h03, 7, 1'b1, 1'b0);
        chk(cnt == 0 && va === 1'b0 && vo === video_in, "code zero line");
        // raw clamped, pins running; then mixed mode on code 3
        for (int k = 0; k < 3; k++) begin
            v = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($urandom_range(254, 129));
            src_hi <= v; src_lo <= v; src_word <= (v > 8'h80) ? 16'hffff : 16'h0;
            run_line((k == 2) ? 8'h1b : 8'h07, 7, 1'b1, 1'b1);
            chk(va === 1'b1 && vo === clamp(v), "raw sample");
            chk(cnt == 84, "pins in raw mode");
        end
        finish_test();
    end
endmodule : vbs_slicer_tb_top
